// ---- sss_ctrl_model.sv ----
// Controller-side model driving the SRAM memory bus and sleep pin
`timescale 1ns/1ps
`default_nettype none
module sss_ctrl_model (
  input  wire logic              pclk,
  output var  sss_pkg::sss_bus_t bus,
  output var  logic              sleep_request
);
  // Power up deselected, with no strobe and no write condition
  initial begin
    bus = '1;
    sleep_request = 1'b0;
  end

  // Release the bus: strobes and write enables off, old data inverted,
  // so a design that keeps sampling stale data cannot pass by luck
  task automatic idle();
    bus <= {bus.addr, ~bus.wdata, bus[10:8], 8'hFF};
  endtask

  // One strobed cycle; s = select pins, p high = processor strobe
  task automatic op(input logic [2:0] s, input logic p, g, b,
                    input logic [3:0] l,
                    input logic [sss_pkg::ADDR_W-1:0] a,
                    input logic [35:0] d);
    @(posedge pclk);
    bus <= {a, d, s, ~p, p, g, b, l};
    @(posedge pclk);
    idle();
  endtask

  // strobed deselect cycle first, then sleep
  task automatic doze(input int n);
    @(posedge pclk);
    bus <= {bus.addr, bus.wdata, 3'b100, 8'hBF};
    @(posedge pclk);
    idle();
    sleep_request <= 1'b1;
    repeat (n) @(posedge pclk);
    sleep_request <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- sss_pkg.sv ----
// Shared constants and types for the synchronous SRAM access block
package sss_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;

  // Power-up wait before the first access, and its cycle count at pclk
  localparam int PCLK_HZ           = 20000000;
  localparam int POWERUP_WAIT_US   = 1000;
  localparam int POWERUP_WAIT_CYC  = (POWERUP_WAIT_US * (PCLK_HZ / 1000000));

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control fields
  localparam int CTRL_OUT_DISABLE_BIT = 0;
  localparam logic CTRL_OUT_DISABLE_RST = 1'b0;

  // Status fields
  localparam int ST_SELECTED_BIT   = 0;
  localparam int ST_SLEEPING_BIT   = 1;
  localparam int ST_DRIVING_BIT    = 2;
  localparam int ST_PWR_READY_BIT  = 3;
  localparam int ST_EARLY_BIT      = 4;

  // Memory bus inputs from the processor or cache controller
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              primary_select_n;
    logic              expansion_select_high;
    logic              expansion_select_low_n;
    logic              processor_address_strobe_n;
    logic              controller_address_strobe_n;
    logic              global_write_n;
    logic              byte_write_enable_n;
    logic [LANES-1:0]  lane_write_select_n;
  } sss_bus_t;
endpackage

// ---- sss_sram.sv ----
// Synchronous flow-through SRAM with select, write, sleep and APB status
`timescale 1ns/1ps
`default_nettype none

module sss_sram #(
  parameter int POWERUP_CYC = sss_pkg::POWERUP_WAIT_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire sss_pkg::sss_bus_t          bus,
  input  wire logic                       output_enable_n,
  input  wire logic                       sleep_request,
  output var  logic [sss_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe
);
  localparam int LN = sss_pkg::LANES;
  localparam int LW = sss_pkg::LANE_W;

  logic [sss_pkg::DATA_W-1:0] mem [0:(1<<sss_pkg::ADDR_W)-1];
  logic [sss_pkg::ADDR_W-1:0] addr_q;
  logic                       active_sel;
  logic                       read_drive;
  logic                       sleeping;
  logic                       out_disable;
  logic                       early_access;
  logic [15:0]                pwr_cnt;
  logic                       pwr_ready;
  logic                       sel;
  logic                       strobe;
  logic                       start;
  logic                       cont_wr;
  logic [LN-1:0]              lane_we;
  logic                       any_wr;
  logic                       wr_now;
  logic [sss_pkg::ADDR_W-1:0] wr_addr;

  assign sel = ~bus.primary_select_n & bus.expansion_select_high &
               ~bus.expansion_select_low_n;
  assign strobe = ~bus.processor_address_strobe_n |
                  ~bus.controller_address_strobe_n;
  // No access starts while asleep or while sleep is being requested
  assign start = strobe & sel & ~sleeping & ~sleep_request;
  // Burst continuation writes reuse the latched address
  assign cont_wr = ~strobe & active_sel & ~sleeping & ~sleep_request;

  // full write via global write; per-lane byte write
  always_comb begin
    for (int i = 0; i < LN; i++) begin
      lane_we[i] = ~bus.global_write_n |
                   (~bus.byte_write_enable_n & ~bus.lane_write_select_n[i]);
    end
  end
  assign any_wr  = |lane_we;
  assign wr_now  = (start | cont_wr) & any_wr;
  assign wr_addr = start ? bus.addr : addr_q;

  // lane-masked array write; array has no reset, contents are undefined
  always_ff @(posedge pclk) begin
    for (int i = 0; i < LN; i++) begin
      if (wr_now && lane_we[i]) begin
        mem[wr_addr][i*LW +: LW] <= bus.wdata[i*LW +: LW];
      end
    end
  end

  // Address latch and selection state of the current access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q     <= '0;
      active_sel <= 1'b0;
    end else if (sleeping || sleep_request) begin
      active_sel <= 1'b0;
    end else if (strobe) begin
      // a strobe while deselected ends the access
      active_sel <= sel;
      if (sel) begin
        addr_q <= bus.addr;
      end
    end
  end

  // read data path; writes and sleep drop the drive until a new read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_drive <= 1'b0;
      dq_out     <= '0;
    end else if (sleeping || sleep_request) begin
      // nothing is driven on wake, a fresh read is needed
      read_drive <= 1'b0;
    end else if (wr_now) begin
      read_drive <= 1'b0;
    end else if (start) begin
      read_drive <= 1'b1;
      dq_out     <= mem[bus.addr];
    end else if (strobe) begin
      read_drive <= 1'b0; // Deselect cycle
    end
  end

  // Sleep state follows the request one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= sleep_request;
    end
  end

  // output enable gates the pins with no clock in the path
  always_comb begin
    dq_oe = read_drive & ~output_enable_n & ~out_disable;
  end

  // Power-up wait counter; the block only reports early accesses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cnt   <= '0;
      pwr_ready <= 1'b0;
    end else if (!pwr_ready) begin
      if (pwr_cnt >= 16'(POWERUP_CYC - 1)) begin
        pwr_ready <= 1'b1;
      end else begin
        pwr_cnt <= pwr_cnt + 16'h0001;
      end
    end
  end

  // APB: no wait states, answer registered from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr[7:0])
          sss_pkg::CTRL_OFS: begin
            prdata[sss_pkg::CTRL_OUT_DISABLE_BIT] <= out_disable;
          end
          sss_pkg::STATUS_OFS: begin
            prdata[sss_pkg::ST_SELECTED_BIT]  <= active_sel;
            prdata[sss_pkg::ST_SLEEPING_BIT]  <= sleeping;
            prdata[sss_pkg::ST_DRIVING_BIT]   <= read_drive;
            prdata[sss_pkg::ST_PWR_READY_BIT] <= pwr_ready;
            prdata[sss_pkg::ST_EARLY_BIT]     <= early_access;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
        if (paddr[31:8] != 24'h000000) begin
          pslverr <= 1'b1;
          prdata  <= '0;
        end
      end
    end
  end

  // Control register write at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_disable <= sss_pkg::CTRL_OUT_DISABLE_RST;
    end else if (psel && penable && pready && pwrite &&
                 paddr == {24'h000000, sss_pkg::CTRL_OFS}) begin
      out_disable <= pwdata[sss_pkg::CTRL_OUT_DISABLE_BIT];
    end
  end

  // Sticky early-access flag, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_access <= 1'b0;
    end else if (start && !pwr_ready) begin
      early_access <= 1'b1;
    end else if (psel && penable && pready && pwrite &&
                 paddr == {24'h000000, sss_pkg::STATUS_OFS} &&
                 pwdata[sss_pkg::ST_EARLY_BIT]) begin
      early_access <= 1'b0;
    end
  end

  // Helpers that let the checks compare the array with its expected word
  logic [sss_pkg::ADDR_W-1:0] chk_addr;
  logic [sss_pkg::DATA_W-1:0] chk_expect;
  logic                       chk_wr;
  logic                       chk_full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_addr   <= '0;
      chk_expect <= '0;
      chk_wr     <= 1'b0;
      chk_full   <= 1'b0;
    end else begin
      chk_wr   <= wr_now;
      chk_full <= wr_now & (&lane_we);
      chk_addr <= wr_addr;
      for (int i = 0; i < LN; i++) begin
        chk_expect[i*LW +: LW] <= lane_we[i] ? bus.wdata[i*LW +: LW] :
                                  mem[wr_addr][i*LW +: LW];
      end
    end
  end

  sequence s_asleep;
    sleeping;
  endsequence
  sequence s_awake;
    !sleeping;
  endsequence

  chk_select_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (strobe && !sel) |=> (!read_drive && !active_sel))
    else $error("Strobe while deselected left an access active");
  // Expected word is the bus data itself, not the lane enables
  chk_full_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_now && (!bus.global_write_n ||
      (!bus.byte_write_enable_n && bus.lane_write_select_n == 4'h0))) |=>
      (chk_full && mem[chk_addr] == $past(bus.wdata)))
    else $error("Full write did not write the whole word");
  chk_idle_after_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_now ##1 !start[*2]) |-> !read_drive)
    else $error("Outputs driven after write without new read");
  chk_wake_hiz: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_asleep ##1 s_awake) |-> !dq_oe)
    else $error("Data driven on leaving sleep");
  chk_oe_async: assert property (
    @(posedge pclk) disable iff (!presetn)
    dq_oe == (read_drive && !output_enable_n && !out_disable))
    else $error("Output enable does not gate the data pins");
  chk_lane_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    chk_wr |-> mem[chk_addr] == chk_expect)
    else $error("Byte write disturbed an unselected lane");
endmodule
`default_nettype wire

// ---- tb_sss_sram.sv ----
// Self-checking bench for the synchronous SRAM access block
`timescale 1ns/1ps
`default_nettype none
module tb_sss_sram;
  localparam int          PWR = 8;
  localparam logic [2:0]  SEL = 3'b010;
  localparam logic [35:0] D1  = 36'h9_A5C3_1E7F;
  localparam logic [35:0] D2  = 36'h6_5A3C_E180;
  localparam logic [35:0] LM  = {9'h0, 9'h1FF, 9'h0, 9'h1FF};
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic              pslverr, oe_n, sleep_request, dq_oe, err;
  logic [31:0]       paddr, pwdata, prdata, rd;
  logic [35:0]       dq_out;
  sss_pkg::sss_bus_t bus;
  int                n_errors, checked, cycles;

  sss_sram #(.POWERUP_CYC(PWR)) sss_sram_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus),
    .output_enable_n(oe_n), .sleep_request(sleep_request),
    .dq_out(dq_out), .dq_oe(dq_oe));
  sss_ctrl_model sss_ctrl_model_inst (
    .pclk(pclk), .bus(bus), .sleep_request(sleep_request));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Hang guard, far above the roughly 100 cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // APB transfer: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b0, 32'h0, 32'h0);
    check(36'(rd), 36'h0);
    apb(1'b0, 32'h4, 32'h0);
    check(36'(rd[sss_pkg::ST_PWR_READY_BIT]), 36'h0);
    apb(1'b1, 32'h8, 32'hFFFF_FFFF);
    check(36'(err), 36'h1);
    // first access only after the wait
    repeat (PWR) @(posedge pclk);
    apb(1'b0, 32'h4, 32'h0);
    check(36'(rd[sss_pkg::ST_PWR_READY_BIT]), 36'h1);
    check(36'(rd[sss_pkg::ST_EARLY_BIT]), 36'h0);
    $display("t_regs done");
  endtask

  task automatic t_full();
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b0, 1'b1, 4'hF, 20'h10, D1);
    #1 check(36'(dq_oe), 36'h0);
    sss_ctrl_model_inst.op(SEL, 1'b0, 1'b1, 1'b1, 4'hF, 20'h10, D2);
    #1 check(dq_out, D1);
    check(36'(dq_oe), 36'h1);
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b0, 4'h0, 20'h11, D2);
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b1, 4'hF, 20'h11, D1);
    #1 check(dq_out, D2);
    $display("t_full done");
  endtask

  task automatic t_lanes();
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b0, 1'b1, 4'hF, 20'h20, D1);
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b0, 4'hA, 20'h20, D2);
    sss_ctrl_model_inst.op(SEL, 1'b0, 1'b1, 1'b1, 4'hF, 20'h20, D1);
    #1 check(dq_out, (D2 & LM) | (D1 & ~LM));
    $display("t_lanes done");
  endtask

  task automatic t_select();
    for (int s = 0; s < 8; s++) begin
      sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b1, 4'hF, 20'h10, D2);
      sss_ctrl_model_inst.op(3'(s), 1'b0, 1'b1, 1'b1, 4'hF, 20'h10, D2);
      #1 check(36'(dq_oe), 36'(3'(s) == SEL));
    end
    $display("t_select done");
  endtask

  task automatic t_oe();
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b1, 4'hF, 20'h10, D2);
    @(posedge pclk);
    oe_n <= 1'b1;
    #1 check(36'(dq_oe), 36'h0);
    @(posedge pclk);
    oe_n <= 1'b0;
    #1 check(36'(dq_oe), 36'h1);
    apb(1'b1, 32'h0, 32'h1);
    #1 check(36'(dq_oe), 36'h0);
    apb(1'b1, 32'h0, 32'h0);
    #1 check(36'(dq_oe), 36'h1);
    // Selected, driving and power ready; not asleep, no early access
    apb(1'b0, 32'h4, 32'h0);
    check(36'(rd), 36'hD);
    $display("t_oe done");
  endtask

  task automatic t_sleep();
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b1, 4'hF, 20'h10, D2);
    sss_ctrl_model_inst.doze(3);
    #1 check(36'(dq_oe), 36'h0);
    sss_ctrl_model_inst.op(SEL, 1'b1, 1'b1, 1'b1, 4'hF, 20'h10, D2);
    #1 check(dq_out, D1);
    $display("t_sleep done");
  endtask

  // Reset for 6 cycles, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, oe_n} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_full();
    t_lanes();
    t_select();
    t_oe();
    t_sleep();
    wrap_up();
  end
endmodule
`default_nettype wire
